// >>> common/tism_if.sv
// carrier between the register front end and the status bit store
`timescale 1ns/100ps
interface tism_if;
  logic [tism_pkg::NSRC-1:0] evt;
  logic [tism_pkg::NSRC-1:0] clr;
  logic [tism_pkg::NSRC-1:0] raw;

  // front end drives events and clears, reads status
  modport ctl (output evt, output clr, input raw);
  // store takes events and clears, shows status
  modport store (input evt, input clr, output raw);
endinterface

// >>> common/tism_pkg.sv
// constants and layout helpers for the timer interrupt status and mask block
package tism_pkg;

  // number of event sources held internally, packed order below
  localparam int unsigned NSRC = 7;

  // internal source index
  localparam int unsigned SRC_A_TIMEOUT = 0;
  localparam int unsigned SRC_A_CAP_MATCH = 1;
  localparam int unsigned SRC_A_CAP_EVENT = 2;
  localparam int unsigned SRC_RTC_EVENT = 3;
  localparam int unsigned SRC_B_TIMEOUT = 4;
  localparam int unsigned SRC_B_CAP_MATCH = 5;
  localparam int unsigned SRC_B_CAP_EVENT = 6;

  // register byte offsets within one timer instance
  localparam logic [11:0] OFS_INT_MASK = 12'h018;
  localparam logic [11:0] OFS_RAW_STAT = 12'h01c;
  localparam logic [11:0] OFS_MSK_STAT = 12'h020;
  localparam logic [11:0] OFS_INT_CLR = 12'h024;

  // field positions in the 32-bit register word
  localparam int unsigned POS_A_LO = 0;
  localparam int unsigned POS_A_HI = 3;
  localparam int unsigned POS_B_LO = 8;
  localparam int unsigned POS_B_HI = 10;

  // reset values
  localparam logic [NSRC-1:0] MASK_RST = 7'h00;
  localparam logic [NSRC-1:0] RAW_RST = 7'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // spread the packed sources onto their register bit positions
  function automatic logic [31:0] to_word(input logic [NSRC-1:0] v);
    logic [31:0] w;
    w = 32'h0000_0000; // reserved bits stay zero
    w[POS_A_HI:POS_A_LO] = v[3:0]; // sub-timer a and rtc
    w[POS_B_HI:POS_B_LO] = v[6:4]; // sub-timer b
    return w;
  endfunction

  // gather register bit positions back into packed sources
  function automatic logic [NSRC-1:0] from_word(input logic [31:0] w);
    return {w[POS_B_HI:POS_B_LO], w[POS_A_HI:POS_A_LO]};
  endfunction

endpackage

// >>> logic/tism_evt.sv
// sticky raw status bits, one per event source
`timescale 1ns/100ps
module tism_evt (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // events, clears and status
  tism_if.store bus
);

  typedef struct packed {
    logic [tism_pkg::NSRC-1:0] raw;
  } tism_evt_st_type;

  tism_evt_st_type state_r;
  tism_evt_st_type state_nxt;

  // one sticky bit per source; an event in the clear cycle still lands
  always_comb begin
    state_nxt = state_r;
    for (int i = 0; i < tism_pkg::NSRC; i++) begin
      if (bus.evt[i]) begin
        state_nxt.raw[i] = 1'b1; // set regardless of mask
      end else if (bus.clr[i]) begin
        state_nxt.raw[i] = 1'b0; // write-one clear
      end
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r.raw <= tism_pkg::RAW_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign bus.raw = state_r.raw;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // per source: set beats clear, clear alone drops the bit
  for (genvar g = 0; g < tism_pkg::NSRC; g++) begin : g_chk
    set_wins_a: assert property (bus.evt[g] |=> bus.raw[g])
      else $error("event lost against clear");
    clr_drop_a: assert property (bus.clr[g] && !bus.evt[g] |=> !bus.raw[g])
      else $error("clear did not drop raw bit");
    hold_a: assert property (!bus.clr[g] && !bus.evt[g] |=> bus.raw[g] == $past(bus.raw[g]))
      else $error("raw bit changed without cause");
  end

endmodule // tism_evt

// >>> logic/tism_top.sv
// register front end, mask and interrupt output of the timer interrupt block
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module tism_top #(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // event pulses from sub-timer a
  input wire logic i_a_timeout,
  input wire logic i_a_capture_match,
  input wire logic i_a_capture_event,
  // event pulse from the rtc
  input wire logic i_rtc_event,
  // event pulses from sub-timer b
  input wire logic i_b_timeout,
  input wire logic i_b_capture_match,
  input wire logic i_b_capture_event,
  // controller interrupt
  output logic o_irq
);

  // the offsets need at least six address bits to decode
  if (ADDR_W < 6) begin : g_bad_addr
    $error("tism_top: ADDR_W must be at least 6");
  end

  typedef struct packed {
    logic [tism_pkg::NSRC-1:0] mask;
    logic [31:0] rdata;
  } tism_top_st_type;

  tism_top_st_type state_r;
  tism_top_st_type state_nxt;

  tism_if sbus ();

  logic [ADDR_W-1:0] ofs_mask;
  logic [ADDR_W-1:0] ofs_raw;
  logic [ADDR_W-1:0] ofs_mis;
  logic [ADDR_W-1:0] ofs_clr;
  logic [tism_pkg::NSRC-1:0] masked;
  logic hit_mask;
  logic hit_raw;
  logic hit_mis;
  logic hit_clr;

  // offsets widened to the address port; upper bits must be zero to hit
  assign ofs_mask = ADDR_W'(tism_pkg::OFS_INT_MASK);
  assign ofs_raw = ADDR_W'(tism_pkg::OFS_RAW_STAT);
  assign ofs_mis = ADDR_W'(tism_pkg::OFS_MSK_STAT);
  assign ofs_clr = ADDR_W'(tism_pkg::OFS_INT_CLR);

  // full address compare, so aliases and unaligned offsets miss
  assign hit_mask = (i_addr == ofs_mask);
  assign hit_raw = (i_addr == ofs_raw);
  assign hit_mis = (i_addr == ofs_mis);
  assign hit_clr = (i_addr == ofs_clr);

  // event pulses packed in internal source order
  assign sbus.evt[tism_pkg::SRC_A_TIMEOUT] = i_a_timeout;
  assign sbus.evt[tism_pkg::SRC_A_CAP_MATCH] = i_a_capture_match;
  assign sbus.evt[tism_pkg::SRC_A_CAP_EVENT] = i_a_capture_event;
  assign sbus.evt[tism_pkg::SRC_RTC_EVENT] = i_rtc_event;
  assign sbus.evt[tism_pkg::SRC_B_TIMEOUT] = i_b_timeout;
  assign sbus.evt[tism_pkg::SRC_B_CAP_MATCH] = i_b_capture_match;
  assign sbus.evt[tism_pkg::SRC_B_CAP_EVENT] = i_b_capture_event;

  // a one written to the clear register clears; zeros leave status alone
  assign sbus.clr = (i_wr && hit_clr) ? tism_pkg::from_word(i_wdata) : '0;

  // masked status is derived, never stored, so it cannot drift from raw
  assign masked = sbus.raw & state_r.mask;

  // level interrupt, falls as soon as the last masked bit is cleared
  assign o_irq = |masked;

  assign o_rdata = state_r.rdata;

  // raw status bit store
  tism_evt u_evt (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .bus(sbus)
  );

  // register writes and read data; read data live one cycle only
  always_comb begin
    state_nxt = state_r;
    state_nxt.rdata = tism_pkg::RDATA_RST;
    if (i_wr && hit_mask) begin
      state_nxt.mask = tism_pkg::from_word(i_wdata);
    end
    if (i_rd) begin
      if (hit_mask) begin
        state_nxt.rdata = tism_pkg::to_word(state_r.mask);
      end else if (hit_raw) begin
        state_nxt.rdata = tism_pkg::to_word(sbus.raw);
      end else if (hit_mis) begin
        state_nxt.rdata = tism_pkg::to_word(masked);
      end
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r.mask <= tism_pkg::MASK_RST;
      state_r.rdata <= tism_pkg::RDATA_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // mask write lands and reads back in layout
  mask_store_a: assert property (
    i_wr && hit_mask ##1 i_rd && hit_mask && !i_wr
    |=> o_rdata == (32'h0000_070f & $past(i_wdata, 2)))
    else $error("mask write not read back");

  // mask bit 0 gates sub-timer a time-out
  mask_a_pos_a: assert property (
    i_wr && hit_mask && i_wdata[0] ##1 i_a_timeout && !(i_wr && hit_mask)
    ##1 !(i_wr && (hit_mask || hit_clr)) [*1] |-> o_irq)
    else $error("bit 0 enable did not pass time-out");

  // mask bit 3 gates the rtc event
  mask_rtc_pos_a: assert property (
    state_r.mask == 7'h08 && i_rtc_event && !(i_wr && (hit_mask || hit_clr))
    |=> o_irq ##0 (masked == 7'h08))
    else $error("bit 3 enable did not pass rtc event");

  // mask bit 10 gates sub-timer b capture event, others blocked
  mask_b_pos_a: assert property (
    i_wr && hit_mask && i_wdata == 32'h0000_0400
    |=> state_r.mask == 7'h40)
    else $error("bit 10 enable misplaced");

  // all enables zero right after reset
  mask_reset_a: assert property (
    $rose(!i_sys_rst) |-> state_r.mask == 7'h00 && !o_irq)
    else $error("mask not clear after reset");

  // raw status sets even with every enable off
  raw_set_a: assert property (
    state_r.mask == 7'h00 && i_b_capture_match && !(i_wr && hit_mask) |=> sbus.raw[5] && !o_irq)
    else $error("raw bit missing or leaked while masked");

  // raw read shows bits in place, reserved as zero
  raw_read_a: assert property (
    i_rd && hit_raw
    |=> o_rdata == {21'h000000, $past(sbus.raw[6:4]), 4'h0, $past(sbus.raw[3:0])})
    else $error("raw read layout wrong");

  // clear write of one drops raw bit without a new event
  clr_raw_a: assert property (
    i_wr && hit_clr && i_wdata[8] && !i_b_timeout |=> !sbus.raw[4])
    else $error("clear did not drop raw bit");

  // masked bit needs both enable and raw event
  mis_and_a: assert property (
    i_rd && hit_mis |=> o_rdata == tism_pkg::to_word($past(sbus.raw) & $past(state_r.mask)))
    else $error("masked read not raw and mask");

  // clearing all sources drops every masked bit
  clr_mis_a: assert property (
    i_wr && hit_clr && (i_wdata & 32'h0000_070f) == 32'h0000_070f && !(|sbus.evt)
    |=> masked == 7'h00 && !o_irq)
    else $error("clear left masked status set");

  // masked read bit 0 is sub-timer a time-out
  mis_pos_a: assert property (
    i_rd && hit_mis |=> o_rdata[0] == ($past(sbus.raw[0]) && $past(state_r.mask[0])))
    else $error("masked bit 0 wrong");

  // reserved bits read zero, unmapped reads zero
  rsvd_zero_a: assert property (
    i_rd |=> o_rdata[31:11] == 21'h000000 && o_rdata[7:4] == 4'h0)
    else $error("reserved bits not zero");
  unmapped_a: assert property (
    i_rd && !(hit_mask || hit_raw || hit_mis) |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // read data stands one cycle only
  rdata_once_a: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data held past its cycle");

  // zero bits in a clear write leave raw status
  clr_zero_a: assert property (
    i_wr && hit_clr && i_wdata == 32'h0000_0000 && !(|sbus.evt) |=> sbus.raw == $past(sbus.raw))
    else $error("zero clear changed status");

  // interrupt follows the masked bits in the same cycle
  irq_level_a: assert property (
    (sbus.raw[2] && state_r.mask[2]) |-> o_irq)
    else $error("interrupt low with masked bit set");
  irq_fall_a: assert property (
    $fell(o_irq) |-> masked == 7'h00 && $past(i_wr))
    else $error("interrupt fell without a write");

endmodule // tism_top

// >>> tb/tism_top_tb.sv
// self-checking bench for the timer interrupt status and mask block
`timescale 1ns/100ps
module tism_top_tb;
  // implemented bit positions of every status and mask word
  localparam logic [31:0] IMPL = 32'h0000_070f;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic i_a_timeout = 1'b0;
  logic i_a_capture_match = 1'b0;
  logic i_a_capture_event = 1'b0;
  logic i_rtc_event = 1'b0;
  logic i_b_timeout = 1'b0;
  logic i_b_capture_match = 1'b0;
  logic i_b_capture_event = 1'b0;
  logic o_irq;
  int failures = 0;
  int checked = 0;
  logic [31:0] mask_m = 32'h0000_0000;
  logic [31:0] raw_m = 32'h0000_0000;
  int src [7] = '{0, 1, 2, 3, 8, 9, 10};
  // expectation for the cycle taken at the last edge, compared one step later
  logic [31:0] pend_rd = 32'h0000_0000;
  logic pend_irq = 1'b0;
  logic pend_v = 1'b0;

  tism_top #(.ADDR_W(12)) i_tism_top (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_a_timeout(i_a_timeout),
    .i_a_capture_match(i_a_capture_match),
    .i_a_capture_event(i_a_capture_event),
    .i_rtc_event(i_rtc_event),
    .i_b_timeout(i_b_timeout),
    .i_b_capture_match(i_b_capture_match),
    .i_b_capture_event(i_b_capture_event),
    .o_irq(o_irq)
  );

  // 50 mhz system clock
  always #10 i_clk = ~i_clk;

  // print counts and verdict, then stop
  task automatic end_sim;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // model read value, taken before the edge's own updates land
  function automatic logic [31:0] rd_model(input logic [11:0] a);
    case (a)
      12'h018: return mask_m;
      12'h01c: return raw_m;
      12'h020: return raw_m & mask_m;
      default: return 32'h0000_0000;
    endcase
  endfunction

  // compare what the cycle taken at the last edge produced
  task automatic check_pend;
    if (pend_v) begin
      chk(o_rdata, pend_rd);
      chk({31'h0, o_irq}, {31'h0, pend_irq});
    end
    pend_v = 1'b0;
  endtask

  // one bus cycle driven at this edge; back to back calls leave no idle gap
  task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d,
                    input logic [31:0] e);
    logic [31:0] exp;
    logic [31:0] clr;
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    {i_b_capture_event, i_b_capture_match, i_b_timeout} <= e[10:8];
    {i_rtc_event, i_a_capture_event, i_a_capture_match, i_a_timeout} <= e[3:0];
    // read sees the state before this cycle's own updates land
    exp = rd_model(a);
    if (w && a == 12'h018) begin
      mask_m = d & IMPL;
    end
    clr = (w && a == 12'h024) ? d : 32'h0000_0000;
    // a set in the same cycle as its clear wins
    raw_m = ((raw_m & ~clr) | e) & IMPL;
    #1;
    check_pend;
    pend_rd = r ? exp : 32'h0000_0000;
    pend_irq = |(raw_m & mask_m);
    pend_v = 1'b1;
    @(posedge i_clk);
  endtask

  // synchronous reset held for n edges, bus idle, model cleared alongside
  task automatic do_rst(input int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    {i_b_capture_event, i_b_capture_match, i_b_timeout} <= 3'h0;
    {i_rtc_event, i_a_capture_event, i_a_capture_match, i_a_timeout} <= 4'h0;
    i_sys_rst <= 1'b1;
    #1;
    check_pend;
    repeat (n) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    mask_m = 32'h0000_0000;
    raw_m = 32'h0000_0000;
    // first request waits one edge past the one that sees reset low
    @(posedge i_clk);
  endtask

  // hang guard, far beyond the real run length
  initial begin
    #200us;
    failures++;
    end_sim;
  end

  initial begin
    logic [31:0] b;
    int k;
    void'($urandom(80426));
    do_rst(20);
    // each of the first 16 words of the space reads its reset value, unmapped ones zero
    for (int a = 0; a < 16; a++) op(1'b0, 1'b1, 12'(a * 4), 32'h0, 32'h0);
    // mask stores written value, reserved bits drop
    repeat (4) begin
      op(1'b1, 1'b0, 12'h018, $urandom(), 32'h0);
      op(1'b0, 1'b1, 12'h018, 32'h0, 32'h0);
    end
    op(1'b1, 1'b0, 12'h018, IMPL, 32'h0);
    op(1'b0, 1'b0, 12'h000, 32'h0, IMPL);
    op(1'b1, 1'b0, 12'h01c, 32'h0, 32'h0);
    op(1'b1, 1'b0, 12'h020, 32'h0, 32'h0);
    op(1'b1, 1'b0, 12'h024, 32'h0, 32'h0);
    op(1'b0, 1'b1, 12'h01c, 32'h0, 32'h0);
    op(1'b0, 1'b1, 12'h020, 32'h0, 32'h0);
    op(1'b0, 1'b1, 12'h024, 32'h0, 32'h0);
    op(1'b1, 1'b0, 12'h024, 32'hffff_ffff, 32'h0);
    // each source alone: masked set, unmask, set-over-clear, clear
    foreach (src[i]) begin
      b = 32'h1 << src[i];
      op(1'b1, 1'b0, 12'h018, 32'h0, 32'h0);
      op(1'b0, 1'b0, 12'h000, 32'h0, b);
      op(1'b0, 1'b1, 12'h020, 32'h0, 32'h0);
      op(1'b0, 1'b1, 12'h01c, 32'h0, 32'h0);
      op(1'b1, 1'b0, 12'h018, b, 32'h0);
      op(1'b0, 1'b1, 12'h020, 32'h0, b);
      op(1'b1, 1'b0, 12'h024, b, b);
      op(1'b1, 1'b0, 12'h024, ~b, 32'h0);
      op(1'b1, 1'b0, 12'h024, b, 32'h0);
      op(1'b0, 1'b1, 12'h01c, 32'h0, 32'h0);
    end
    // random mix of events, mask writes, clears and reads
    repeat (300) begin
      k = $urandom_range(0, 2);
      op(k == 1, k == 2, 12'($urandom_range(5, 10) * 4), $urandom(), $urandom() & $urandom());
    end
    // reset in mid-run drops mask and status
    op(1'b1, 1'b0, 12'h018, IMPL, IMPL);
    do_rst(2);
    op(1'b0, 1'b1, 12'h018, 32'h0, 32'h0);
    op(1'b0, 1'b1, 12'h01c, 32'h0, 32'h0);
    // idle cycle lets the last read be compared
    op(1'b0, 1'b0, 12'h000, 32'h0, 32'h0);
    end_sim;
  end
endmodule // tism_top_tb
